// File: rfhrp_host.sv
// host model: makes the interface clock in bursts, drives the released bus
// assumes pclk at 250 MHz and an interface clock slow against it
module rfhrp_host (
	input  wire logic        pclk,
	input  wire logic        bus_oe,
	input  wire logic [11:0] bus_o,
	output logic             iface_clk,
	output logic      [11:0] bus_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] pat = 12'h000;
	initial iface_clk = 1'b0;
	// a released bus shows a moving pattern, never the last value
	always @(posedge pclk) pat <= pat + 12'h5A3;
	assign bus_i = bus_oe ? bus_o : pat;
	// clock stands still between bursts; at least four pclk per phase for the synchroniser
	task automatic clocks(input int n);
		repeat (n) begin
			@(posedge pclk);
			iface_clk <= 1'b1;
			repeat (4) @(posedge pclk);
			iface_clk <= 1'b0;
			repeat (4) @(posedge pclk);
		end
	endtask
endmodule

// File: rfhrp_pkg.sv
// constants for the receive fifo host read port
// assumes a 250 MHz pclk and a 32-bit apb master
package rfhrp_pkg;
	localparam int W = 12;
	localparam int AW = 8;
	localparam int DEPTH = 256;
	localparam logic [8:0] DEPTH_C = 9'h100;
	localparam logic [8:0] FULL_LEVEL = 9'h0F8;
	localparam logic [8:0] HALF_LEVEL = 9'h080;
	localparam logic [2:0] CLEAR_CYCLES = 3'h7;
	localparam logic [2:0] DIV10_HALF = 3'h4;
	localparam logic [2:0] DIV12_HALF = 3'h5;
	// synchronised pin vector positions
	localparam int P_CLK = 0;
	localparam int P_QUAL = 1;
	localparam int P_CAS = 2;
	localparam int P_BYP = 3;
	localparam int P_AM = 4;
	localparam int P_CLR = 5;
	localparam int P_ST = 6;
	localparam int P_RST0 = 7;
	localparam int P_RST1 = 8;
	localparam int NPIN = 9;
	localparam logic [8:0] PIN_RESET = 9'h1FE;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_INT_STAT = 8'h08;
	localparam logic [7:0] OFS_INT_EN = 8'h0C;
	localparam logic [7:0] OFS_INT_CLR = 8'h10;
	localparam logic [0:0] CTRL_RESET = 1'h0;
	localparam int CTRL_DIV12 = 0;
	// status fields
	localparam int ST_COUNT = 0;
	localparam int ST_EMPTY = 9;
	localparam int ST_FULL = 10;
	localparam int ST_HALF = 11;
	localparam int ST_BYPASS = 12;
	// event bits
	localparam int NEV = 5;
	localparam int EV_OVF = 0;
	localparam int EV_UNF = 1;
	localparam int EV_CLR = 2;
	localparam int EV_ST = 3;
	localparam int EV_FULL = 4;
	localparam logic [4:0] EV_RESET = 5'h00;
endpackage

// File: rfhrp_top.sv
// receive fifo, host read port, pin flags and apb status/interrupt block
// pins arrive asynchronously and are synchronised to pclk; the decoder
// and self-test matcher sit on pclk and feed wr_* and selftest_loop_done
//
// Added by the designer: the APB register port and the placing of the registers.
module rfhrp_top (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic                      pready,
	output logic                      pslverr,
	output logic      [31:0]          prdata,
	output logic                      irq,
	input  wire logic [rfhrp_pkg::W-1:0] wr_data,
	input  wire logic                 wr_valid,
	output logic                      wr_ready,
	input  wire logic                 selftest_loop_done,
	input  wire logic                 rx_read_qualify,
	input  wire logic                 cascade_timing_select,
	input  wire logic                 fifo_bypass_n,
	input  wire logic                 device_address_match_n,
	input  wire logic                 rx_fifo_clear_n,
	input  wire logic                 rx_selftest_enable_n,
	input  wire logic [1:0]           chip_reset_n,
	input  wire logic                 rx_iface_clock_i,
	output logic                      rx_iface_clock_o,
	output logic                      rx_iface_clock_oe,
	input  wire logic [rfhrp_pkg::W-1:0] rx_parallel_bus_i,
	output logic      [rfhrp_pkg::W-1:0] rx_parallel_bus_o,
	output logic                      rx_parallel_bus_oe,
	output logic                      rx_full_flag_o,
	output logic                      rx_full_flag_oe,
	output logic                      rx_half_flag_o,
	output logic                      rx_half_flag_oe,
	output logic                      rx_empty_flag_o,
	output logic                      rx_empty_flag_oe,
	output logic                      sar_access
);
	logic [rfhrp_pkg::NPIN-1:0] pin_s1;
	logic [rfhrp_pkg::NPIN-1:0] pin_s2;
	logic                       clk_d;
	logic [rfhrp_pkg::W-1:0]    mem [rfhrp_pkg::DEPTH];
	logic [rfhrp_pkg::AW-1:0]   wr_ptr;
	logic [rfhrp_pkg::AW-1:0]   rd_ptr;
	logic [8:0]                 count;
	logic [8:0]                 next_count;
	logic [rfhrp_pkg::W-1:0]    out_reg;
	logic [2:0]                 div_cnt;
	logic                       gen_clk;
	logic [2:0]                 clr_cnt;
	logic                       ctrl_div12;
	logic [rfhrp_pkg::NEV-1:0]  int_stat;
	logic [rfhrp_pkg::NEV-1:0]  int_en;
	logic                       full_d;

	// the async pin vector, interface clock included, passes two flops;
	// pin_s1 is read by pin_s2 alone
	wire [rfhrp_pkg::NPIN-1:0] pins = {chip_reset_n, rx_selftest_enable_n,
		rx_fifo_clear_n, device_address_match_n, fifo_bypass_n,
		cascade_timing_select, rx_read_qualify, rx_iface_clock_i};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1 <= rfhrp_pkg::PIN_RESET;
			pin_s2 <= rfhrp_pkg::PIN_RESET;
			clk_d  <= 1'b0;
		end else begin
			pin_s1 <= pins;
			pin_s2 <= pin_s1;
			clk_d  <= pin_s2[rfhrp_pkg::P_CLK];
		end
	end

	wire fifo_mode = pin_s2[rfhrp_pkg::P_BYP];
	wire cascade   = pin_s2[rfhrp_pkg::P_CAS];
	wire qual_act  = cascade ? pin_s2[rfhrp_pkg::P_QUAL]
		: ~pin_s2[rfhrp_pkg::P_QUAL];
	wire am        = ~pin_s2[rfhrp_pkg::P_AM];
	wire clr_act   = ~pin_s2[rfhrp_pkg::P_CLR];
	wire st_act    = ~pin_s2[rfhrp_pkg::P_ST];
	wire both_rst  = ~pin_s2[rfhrp_pkg::P_RST0] & ~pin_s2[rfhrp_pkg::P_RST1];

	// bypass clock divider: pclk stands in for the serial bit clock
	wire [2:0] half_per = ctrl_div12 ? rfhrp_pkg::DIV12_HALF
		: rfhrp_pkg::DIV10_HALF;
	wire div_wrap = (div_cnt == half_per);
	wire gen_rise = div_wrap & ~gen_clk;
	wire host_rise = pin_s2[rfhrp_pkg::P_CLK] & ~clk_d;
	wire iface_rise = fifo_mode ? host_rise : gen_rise;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 3'h0;
			gen_clk <= 1'b0;
		end else begin
			div_cnt <= div_wrap ? 3'h0 : div_cnt + 3'h1;
			gen_clk <= div_wrap ? ~gen_clk : gen_clk;
		end
	end

	// fifo bookkeeping
	wire empty_true = (count == 9'h000);
	wire do_wr = wr_valid & wr_ready;
	wire rd_try = iface_rise & fifo_mode & qual_act;
	wire do_rd = rd_try & ~empty_true;
	wire clr_fire = iface_rise & fifo_mode & am & clr_act
		& (clr_cnt == rfhrp_pkg::CLEAR_CYCLES);
	wire full_lvl = (count >= rfhrp_pkg::FULL_LEVEL);
	wire half_lvl = (count >= rfhrp_pkg::HALF_LEVEL);
	wire st_pulse = st_act & selftest_loop_done;

	always_comb begin
		next_count = count + {8'h00, do_wr} - {8'h00, do_rd};
		if (clr_fire)
			next_count = 9'h000;
	end

	always_ff @(posedge pclk) begin
		if (do_wr)
			mem[wr_ptr] <= wr_data;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr   <= 8'h00;
			rd_ptr   <= 8'h00;
			count    <= 9'h000;
			wr_ready <= 1'b0;
			clr_cnt  <= 3'h0;
		end else begin
			wr_ptr   <= clr_fire ? 8'h00 : wr_ptr + {7'h00, do_wr};
			rd_ptr   <= clr_fire ? 8'h00 : rd_ptr + {7'h00, do_rd};
			count    <= next_count;
			wr_ready <= (next_count != rfhrp_pkg::DEPTH_C);
			if (!(fifo_mode & am & clr_act))
				clr_cnt <= 3'h0;
			else if (iface_rise && clr_cnt != rfhrp_pkg::CLEAR_CYCLES)
				clr_cnt <= clr_cnt + 3'h1;
		end
	end

	// bypass output register catches each decoded character
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			out_reg <= '0;
		else if (wr_valid && !fifo_mode)
			out_reg <= wr_data;
	end

	// data bus; an empty read leaves the last value in place
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_parallel_bus_o  <= '0;
			rx_parallel_bus_oe <= 1'b0;
			sar_access         <= 1'b0;
		end else begin
			if (do_rd)
				rx_parallel_bus_o <= mem[rd_ptr];
			else if (iface_rise && !fifo_mode && qual_act)
				rx_parallel_bus_o <= out_reg;
			rx_parallel_bus_oe <= qual_act;
			sar_access <= iface_rise & fifo_mode & qual_act & clr_act & am;
		end
	end

	// flags; full covers fifo level and self-test progress
	wire full_assert = st_pulse
		| (fifo_mode & am & qual_act & full_lvl);
	wire half_assert = fifo_mode & half_lvl;
	wire empty_assert = fifo_mode & empty_true;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_full_flag_o    <= 1'b1;
			rx_full_flag_oe   <= 1'b0;
			rx_half_flag_o    <= 1'b1;
			rx_half_flag_oe   <= 1'b0;
			rx_empty_flag_o   <= 1'b1;
			rx_empty_flag_oe  <= 1'b0;
			rx_iface_clock_o  <= 1'b0;
			rx_iface_clock_oe <= 1'b0;
		end else begin
			rx_full_flag_o    <= cascade ? full_assert : ~full_assert;
			rx_full_flag_oe   <= am;
			rx_half_flag_o    <= ~half_assert;
			rx_half_flag_oe   <= ~both_rst;
			rx_empty_flag_o   <= cascade ? empty_assert : ~empty_assert;
			rx_empty_flag_oe  <= am;
			rx_iface_clock_o  <= gen_clk;
			rx_iface_clock_oe <= ~fifo_mode;
		end
	end

	// apb slave, no wait state: pready rises in the first access cycle
	wire setup   = psel & ~penable;
	wire wr_done = psel & penable & pready & pwrite;
	wire hit_ctrl = (paddr == rfhrp_pkg::OFS_CTRL);
	wire hit_stat = (paddr == rfhrp_pkg::OFS_STATUS);
	wire hit_ist  = (paddr == rfhrp_pkg::OFS_INT_STAT);
	wire hit_ien  = (paddr == rfhrp_pkg::OFS_INT_EN);
	wire hit_iclr = (paddr == rfhrp_pkg::OFS_INT_CLR);
	wire mapped = hit_ctrl | hit_stat | hit_ist | hit_ien | hit_iclr;
	wire [31:0] status_word = {19'h00000, ~fifo_mode, half_assert,
		full_lvl, empty_true, count};
	wire [31:0] rd_mux;
	assign rd_mux = hit_ctrl ? {31'h00000000, ctrl_div12}
		: hit_stat ? status_word
		: hit_ist ? {27'h0000000, int_stat}
		: hit_ien ? {27'h0000000, int_en}
		: 32'h00000000;

	// events; a set in the cycle of a clear wins
	wire [rfhrp_pkg::NEV-1:0] ev;
	assign ev[rfhrp_pkg::EV_OVF]  = wr_valid & ~wr_ready;
	assign ev[rfhrp_pkg::EV_UNF]  = rd_try & empty_true;
	assign ev[rfhrp_pkg::EV_CLR]  = clr_fire;
	assign ev[rfhrp_pkg::EV_ST]   = st_pulse;
	assign ev[rfhrp_pkg::EV_FULL] = full_lvl & ~full_d;
	wire [rfhrp_pkg::NEV-1:0] clr_mask = (wr_done & hit_iclr)
		? pwdata[rfhrp_pkg::NEV-1:0] : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			prdata     <= 32'h00000000;
			ctrl_div12 <= rfhrp_pkg::CTRL_RESET;
			int_stat   <= rfhrp_pkg::EV_RESET;
			int_en     <= rfhrp_pkg::EV_RESET;
			irq        <= 1'b0;
			full_d     <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			prdata  <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
			if (wr_done && hit_ctrl)
				ctrl_div12 <= pwdata[rfhrp_pkg::CTRL_DIV12];
			if (wr_done && hit_ien)
				int_en <= pwdata[rfhrp_pkg::NEV-1:0];
			int_stat <= (int_stat & ~clr_mask) | ev;
			irq      <= |(int_stat & int_en);
			full_d   <= full_lvl;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_clear_seen;
		clr_fire;
	endsequence
	sequence s_emptied;
		count == 9'h000 ##1 rx_empty_flag_o == $past(cascade);
	endsequence

	a_full_polarity: assert property (full_assert |=>
		rx_full_flag_o == $past(cascade)) else $error("full flag polarity wrong");
	a_full_release: assert property (!am |=> !rx_full_flag_oe)
		else $error("full flag driven while not addressed");
	a_half_level: assert property (fifo_mode && count >= 9'h080
		|=> !rx_half_flag_o) else $error("half flag missing at 128");
	a_bypass_flags: assert property (!fifo_mode && !st_pulse |=>
		rx_half_flag_o && rx_full_flag_o == !$past(cascade))
		else $error("flags asserted in bypass");
	a_half_float: assert property (both_rst |=> !rx_half_flag_oe)
		else $error("half flag driven during chip reset");
	a_read_pops: assert property (do_rd && !do_wr && !clr_fire |=>
		count == $past(count) - 9'h001) else $error("read did not pop");
	a_empty_hold: assert property (rd_try && empty_true && !do_wr |=>
		$stable(rx_parallel_bus_o) && count == 9'h000)
		else $error("empty read changed state");
	a_bus_float: assert property (!qual_act |=> !rx_parallel_bus_oe)
		else $error("bus driven while unqualified");
	a_clear_empties: assert property (s_clear_seen |=> s_emptied)
		else $error("clear did not empty fifo");
	a_clock_drive: assert property (!fifo_mode ##1 !fifo_mode
		|-> rx_iface_clock_oe) else $error("clock not driven in bypass");
	a_sar_gate: assert property (sar_access |-> $past(qual_act))
		else $error("sar access without qualify");

	// word at the read pointer, watched by the read data check
	wire [rfhrp_pkg::W-1:0] rd_word = mem[rd_ptr];

	sequence s_chip_running;
		!both_rst ##1 !both_rst;
	endsequence
	sequence s_qual_held;
		qual_act ##1 qual_act;
	endsequence
	sequence s_loop_end;
		st_act && selftest_loop_done;
	endsequence
	sequence s_full_shown;
		rx_full_flag_o == $past(cascade);
	endsequence
	sequence s_full_hidden;
		rx_full_flag_o == !$past(cascade);
	endsequence

	// two-cycle antecedents skip the first edge, where outputs still hold reset values
	a_half_drive: assert property (s_chip_running |=> rx_half_flag_oe)
		else $error("half flag floating outside chip reset");
	a_half_idle: assert property (!half_assert |=> rx_half_flag_o)
		else $error("half flag asserted without level");
	a_half_below: assert property (count < rfhrp_pkg::HALF_LEVEL
		|=> rx_half_flag_o) else $error("half flag early");

	a_full_drive: assert property (am |=> rx_full_flag_oe)
		else $error("full flag not driven while addressed");
	a_full_idle: assert property (am && !full_assert |=> s_full_hidden)
		else $error("full flag asserted without cause");
	a_full_level: assert property (fifo_mode && am && qual_act
		&& count >= rfhrp_pkg::FULL_LEVEL |=> s_full_shown)
		else $error("full flag missing near top");
	a_full_below: assert property (fifo_mode && am && !st_pulse
		&& count < rfhrp_pkg::FULL_LEVEL |=> s_full_hidden)
		else $error("full flag early");
	a_selftest_pulse: assert property (s_loop_end |=> s_full_shown)
		else $error("self-test loop not shown on full flag");

	a_bus_drive: assert property (s_qual_held |=> rx_parallel_bus_oe)
		else $error("bus released while qualified");
	a_read_data: assert property (do_rd |=>
		rx_parallel_bus_o == $past(rd_word)) else $error("read data wrong");
	a_bypass_data: assert property (iface_rise && !fifo_mode && qual_act |=>
		rx_parallel_bus_o == $past(out_reg)) else $error("bypass data wrong");
	a_no_read: assert property (!qual_act && !clr_fire |=> $stable(rd_ptr))
		else $error("read while unqualified");

	a_clock_toggle: assert property (div_wrap |=> gen_clk != $past(gen_clk))
		else $error("generated clock missed a toggle");
	a_clock_steady: assert property (!div_wrap |=> $stable(gen_clk))
		else $error("generated clock toggled early");
	a_clock_release: assert property (fifo_mode |=> !rx_iface_clock_oe)
		else $error("clock driven in fifo mode");

	a_empty_flag: assert property (fifo_mode && empty_true |=>
		rx_empty_flag_o == $past(cascade)) else $error("empty flag missing");
	a_empty_drive: assert property (am |=> rx_empty_flag_oe)
		else $error("empty flag not driven while addressed");
	a_empty_event: assert property (rd_try && empty_true |=>
		int_stat[rfhrp_pkg::EV_UNF]) else $error("empty read not recorded");
	a_clear_count: assert property (!(fifo_mode && am && clr_act) |=>
		clr_cnt == 3'h0) else $error("clear count kept without condition");

	a_depth_cap: assert property (count <= rfhrp_pkg::DEPTH_C)
		else $error("fifo count above depth");
	a_full_stall: assert property (count == rfhrp_pkg::DEPTH_C |-> !wr_ready)
		else $error("write accepted while full");
	a_overflow_event: assert property (wr_valid && !wr_ready |=>
		int_stat[rfhrp_pkg::EV_OVF]) else $error("overflow not recorded");
	a_sar_cond: assert property (sar_access |->
		$past(am) && $past(clr_act) && $past(fifo_mode)) else $error("sar access out of mode");
	a_sar_block: assert property (!qual_act |=> !sar_access)
		else $error("sar access while unqualified");
endmodule

// File: rx_fifo_host_read_port_test.sv
// self-checking bench for the receive fifo host read port
// assumes rfhrp_pkg, rfhrp_top and rfhrp_host are compiled first
module rx_fifo_host_read_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, wr_valid, st_done, seen;
	logic        qual, cas, byp_n, am_n, clr_n, st_n, pready, pslverr, irq, wr_ready;
	logic        hclk, pin_clk, clk_o, clk_oe, bus_oe, full_o, full_oe;
	logic        half_o, half_oe, empty_o, empty_oe, sar;
	int          sar_hits = 0;
	logic [1:0]  chip_rst_n;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [11:0] wr_data, bus_o, bus_i, last;
	logic [32:0] rq[$];
	logic [11:0] dq[$];
	int          bad_count = 0;
	int          num_checks = 0;
	int          cyc = 0;
	time         t0;
	// the clock pin is whoever drives it
	assign pin_clk = clk_oe ? clk_o : hclk;
	rfhrp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .irq(irq), .wr_data(wr_data), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .selftest_loop_done(st_done), .rx_read_qualify(qual),
		.cascade_timing_select(cas), .fifo_bypass_n(byp_n), .device_address_match_n(am_n),
		.rx_fifo_clear_n(clr_n), .rx_selftest_enable_n(st_n), .chip_reset_n(chip_rst_n),
		.rx_iface_clock_i(pin_clk), .rx_iface_clock_o(clk_o), .rx_iface_clock_oe(clk_oe),
		.rx_parallel_bus_i(bus_i), .rx_parallel_bus_o(bus_o), .rx_parallel_bus_oe(bus_oe),
		.rx_full_flag_o(full_o), .rx_full_flag_oe(full_oe), .rx_half_flag_o(half_o),
		.rx_half_flag_oe(half_oe), .rx_empty_flag_o(empty_o), .rx_empty_flag_oe(empty_oe),
		.sar_access(sar));
	rfhrp_host host (.pclk(pclk), .bus_oe(bus_oe), .bus_o(bus_o), .iface_clk(hclk),
		.bus_i(bus_i));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task automatic check(input string nm, input logic [32:0] sv, input logic [32:0] ev);
		num_checks++;
		if (sv !== ev) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, ev, sv);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// read expectations go on the queue; the watcher below compares them
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [32:0] e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) rq.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic put(input logic [11:0] d);
		@(posedge pclk);
		wr_valid <= 1'b1;
		wr_data <= d;
		do @(posedge pclk); while (wr_ready !== 1'b1);
		wr_valid <= 1'b0;
	endtask
	// flags lag the pins by the synchroniser plus one register
	task automatic settle();
		repeat (8) @(posedge pclk);
	endtask
	task automatic period(input time e);
		@(posedge clk_o);
		t0 = $time;
		@(posedge clk_o);
		check("clk period", 33'($time - t0), 33'(e));
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (sar === 1'b1)
			sar_hits <= sar_hits + 1;
		if (cyc == 30000) begin
			bad_count++;
			end_sim();
		end else if (psel && penable && pready === 1'b1 && !pwrite)
			check("prdata", {pslverr, prdata}, rq.pop_front());
	end
	initial begin
		{psel, penable, pwrite, wr_valid, st_done, am_n, presetn} = '0;
		{cas, byp_n, clr_n, st_n, qual} = 5'h1F;
		chip_rst_n = 2'h3;
		paddr = 8'h00;
		pwdata = 32'h0;
		wr_data = 12'h000;
		void'($urandom(32'h7104));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, rfhrp_pkg::OFS_CTRL, 0, 33'h0);
		apb(0, rfhrp_pkg::OFS_STATUS, 0, 33'h200);
		apb(0, rfhrp_pkg::OFS_INT_CLR, 0, 33'h0);
		apb(0, 8'h14, 0, 33'h1_0000_0000);
		apb(1, rfhrp_pkg::OFS_INT_EN, 32'h1F, 0);
		apb(0, rfhrp_pkg::OFS_INT_EN, 0, 33'h1F);
		for (int i = 0; i < 256; i++) begin
			dq.push_back(12'($urandom));
			put(dq[$]);
			if (i == 127) begin
				settle();
				check("half", half_o, 0);
			end
			if (i == 246 || i == 247) begin
				settle();
				check("full", full_o, (i == 247));
			end
		end
		@(posedge pclk);
		check("wr_ready", wr_ready, 0);
		apb(0, rfhrp_pkg::OFS_STATUS, 0, 33'hD00);
		@(posedge pclk) wr_valid <= 1'b1;
		@(posedge pclk) wr_valid <= 1'b0;
		settle();
		check("irq", irq, 1);
		apb(0, rfhrp_pkg::OFS_INT_STAT, 0, 33'h11);
		apb(1, rfhrp_pkg::OFS_INT_CLR, 32'h1F, 0);
		apb(0, rfhrp_pkg::OFS_INT_STAT, 0, 33'h0);
		for (int k = 0; k < 3; k++) begin
			host.clocks(1);
			settle();
			last = dq.pop_front();
			check("bus data", bus_o, last);
		end
		qual <= 1'b0;
		settle();
		check("bus oe", bus_oe, 0);
		host.clocks(1);
		apb(0, rfhrp_pkg::OFS_STATUS, 0, 33'hCFD);
		cas <= 1'b0;
		qual <= 1'b1;
		settle();
		check("full utopia off", full_o, 1);
		qual <= 1'b0;
		settle();
		check("full utopia on", full_o, 0);
		check("bus oe utopia", bus_oe, 1);
		am_n <= 1'b1;
		settle();
		check("full oe", full_oe, 0);
		check("empty oe", empty_oe, 0);
		am_n <= 1'b0;
		qual <= 1'b1;
		clr_n <= 1'b0;
		host.clocks(7);
		apb(0, rfhrp_pkg::OFS_STATUS, 0, 33'hCFD);
		host.clocks(1);
		settle();
		clr_n <= 1'b1;
		apb(0, rfhrp_pkg::OFS_STATUS, 0, 33'h200);
		check("empty", empty_o, 0);
		qual <= 1'b0;
		host.clocks(1);
		settle();
		check("empty read", bus_o, last);
		apb(0, rfhrp_pkg::OFS_INT_STAT, 0, 33'h06);
		clr_n <= 1'b0;
		host.clocks(1);
		clr_n <= 1'b1;
		check("sar strobes", sar_hits, 1);
		chip_rst_n <= 2'h0;
		settle();
		check("half oe rst", half_oe, 0);
		chip_rst_n <= 2'h1;
		settle();
		check("half oe", half_oe, 1);
		cas <= 1'b1;
		st_n <= 1'b0;
		settle();
		@(posedge pclk) st_done <= 1'b1;
		@(posedge pclk) st_done <= 1'b0;
		seen = 1'b0;
		repeat (10) @(posedge pclk) seen = seen | (full_o === 1'b1);
		check("selftest pulse", seen, 1);
		st_n <= 1'b1;
		byp_n <= 1'b0;
		settle();
		check("clk oe", clk_oe, 1);
		check("bypass flags", {half_o, full_o}, 2'h2);
		period(40);
		apb(1, rfhrp_pkg::OFS_CTRL, 32'h1, 0);
		period(48);
		put(12'hA5C);
		qual <= 1'b1;
		repeat (40) @(posedge pclk);
		check("bypass data", {bus_oe, bus_o}, 13'h1A5C);
		end_sim();
	end
endmodule
